// [pcs_consts.vh]
// Constants for the PCM serial port of the single-channel A-law codec.
// Included by the design files; definitions only.
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
`define PCS_WORD_BITS 8
`define PCS_CNT_W 4
`define PCS_LAST_BIT 4'h7
`define PCS_NINTH_BIT 4'h8
`define PCS_SIGN_POS 7
`define PCS_CHORD_HI 6
`define PCS_CHORD_LO 4
`define PCS_STEP_HI 3
`define PCS_STEP_LO 0
`define PCS_SIGN_POS_VAL 1'h1
`define PCS_NULL_CYC 4'h3
`define PCS_CONV_CYC 4'hC
`define PCS_PIN_LANES 4
`define PCS_LANE_TXS 0
`define PCS_LANE_TXC 1
`define PCS_LANE_RXS 2
`define PCS_LANE_RXC 3
`endif

// [pcs_edge_sync.v]
// Two-flop synchroniser with rising and falling edge detect.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module pcs_edge_sync (
  input wire clk,
  input wire rstn,
  input wire asyncIn,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule // pcs_edge_sync

// [pcs_serial_port.v]
// PCM serial port of a single-channel A-law codec: transmit shifter,
// receive shifter and a stand-in conversion sequencer on the master clock.
// Assumes syncs and bit clocks come from an external controller.
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_serial_port (
  input wire clk,
  input wire rstn,
  input wire txFrameStrobe,
  input wire txBitClock,
  output wire txData,
  output wire txDataOe,
  input wire rxFrameStrobe,
  input wire rxBitClock,
  input wire rxData,
  input wire [7:0] adcSample,
  output wire adcStart,
  output wire adcNull,
  output wire [7:0] dacWord,
  output wire dacStart,
  output wire rxWordValid
);
  wire txSyncLvl;
  wire txSyncRise;
  wire txSyncFall;
  wire txClkLvl;
  wire txClkRise;
  wire rxSyncLvl;
  wire rxSyncRise;
  wire rxSyncFall;
  wire rxClkLvl;
  wire rxClkRise;

  wire [3:0] pinAsync;
  wire [3:0] pinLvl;
  wire [3:0] pinRise;
  wire [3:0] pinFall;
  reg rxDataMeta_q;
  reg rxDataSync_q;

  // All link pins are asynchronous to clk, so each passes two flops
  // Bit clock lanes leave their falling edge unread
  assign pinAsync = {rxBitClock, rxFrameStrobe, txBitClock, txFrameStrobe};
  genvar g;
  generate
    for (g = 0; g < `PCS_PIN_LANES; g = g + 1) begin : gPinSync
      pcs_edge_sync uEdge (
        .clk(clk),
        .rstn(rstn),
        .asyncIn(pinAsync[g]),
        .level(pinLvl[g]),
        .rise(pinRise[g]),
        .fall(pinFall[g])
      );
    end
  endgenerate

  assign txSyncLvl = pinLvl[`PCS_LANE_TXS];
  assign txSyncRise = pinRise[`PCS_LANE_TXS];
  assign txSyncFall = pinFall[`PCS_LANE_TXS];
  assign txClkLvl = pinLvl[`PCS_LANE_TXC];
  assign txClkRise = pinRise[`PCS_LANE_TXC];
  assign rxSyncLvl = pinLvl[`PCS_LANE_RXS];
  assign rxSyncRise = pinRise[`PCS_LANE_RXS];
  assign rxSyncFall = pinFall[`PCS_LANE_RXS];
  assign rxClkLvl = pinLvl[`PCS_LANE_RXC];
  assign rxClkRise = pinRise[`PCS_LANE_RXC];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxDataMeta_q <= 1'b0;
      rxDataSync_q <= 1'b0;
    end else begin
      rxDataMeta_q <= rxData;
      rxDataSync_q <= rxDataMeta_q;
    end
  end

  // Transmit section
  reg [7:0] txShift_q;
  reg [7:0] txShift_d;
  reg [3:0] txCnt_q;
  reg [3:0] txCnt_d;
  reg txOut_q;
  reg txOut_d;
  reg txOe_q;
  reg txOe_d;
  reg [7:0] txHold_q;
  reg [7:0] txHold_d;
  reg txFirst_q;
  reg txFirst_d;

  wire txClkEdge;
  wire txLateEdge;
  wire txShiftEdge;
  assign txClkEdge = txSyncLvl & txClkRise;
  // A sync rise while the bit clock is already high stands in for the first edge
  assign txLateEdge = txSyncRise & txClkLvl;
  assign txShiftEdge = txClkEdge | txLateEdge;

  always @* begin
    txShift_d = txShift_q;
    txCnt_d = txCnt_q;
    txOut_d = txOut_q;
    txOe_d = txOe_q;
    txFirst_d = txFirst_q;
    // Each frame reloads the shifter from the last finished conversion
    if (txSyncRise) begin
      txOe_d = 1'b1;
      // Sign bit shows as soon as the driver turns on
      txOut_d = txHold_q[`PCS_SIGN_POS];
      txShift_d = txHold_q;
      txCnt_d = {`PCS_CNT_W{1'b0}};
      txFirst_d = 1'b1;
    end
    if (txShiftEdge && txCnt_d <= `PCS_LAST_BIT) begin
      // Sign bit leaves first, MSB-first through chord and step
      txOut_d = txFirst_d ? txShift_d[`PCS_SIGN_POS] : txShift_q[`PCS_SIGN_POS - 1];
      if (!txFirst_d) begin
        txShift_d = {txShift_q[`PCS_SIGN_POS - 1:0], 1'b0};
      end
      txFirst_d = 1'b0;
      txCnt_d = txCnt_d + 4'h1;
    end
    if (txSyncFall || !txSyncLvl) begin
      txOe_d = 1'b0;
      // Parked low so a stale bit never shows at the next enable
      txOut_d = 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txShift_q <= 8'h00;
      txCnt_q <= 4'h0;
      txOut_q <= 1'b0;
      txOe_q <= 1'b0;
      txFirst_q <= 1'b0;
    end else begin
      txShift_q <= txShift_d;
      txCnt_q <= txCnt_d;
      txOut_q <= txOut_d;
      txOe_q <= txOe_d;
      txFirst_q <= txFirst_d;
    end
  end

  assign txData = txOut_q;
  assign txDataOe = txOe_q;

  // Conversion sequencer: clocked by clk alone, no relation to bit clocks
  localparam CV_IDLE = 2'b00;
  localparam CV_NULL = 2'b01;
  localparam CV_CONV = 2'b10;
  localparam CV_DONE = 2'b11;

  reg [1:0] cvState_q;
  reg [1:0] cvState_d;
  reg [3:0] cvCnt_q;
  reg [3:0] cvCnt_d;
  reg cvPend_q;
  reg cvPend_d;

  always @* begin
    cvState_d = cvState_q;
    cvCnt_d = cvCnt_q;
    // A sync rise during a busy conversion waits in the pending flag
    cvPend_d = cvPend_q | txSyncRise;
    txHold_d = txHold_q;
    case (cvState_q)
      CV_IDLE: begin
        if (cvPend_q) begin
          cvPend_d = txSyncRise;
          cvState_d = CV_NULL;
          cvCnt_d = 4'h0;
        end
      end
      CV_NULL: begin
        cvCnt_d = cvCnt_q + 4'h1;
        if (cvCnt_q == `PCS_NULL_CYC) begin
          cvState_d = CV_CONV;
          cvCnt_d = 4'h0;
        end
      end
      CV_CONV: begin
        cvCnt_d = cvCnt_q + 4'h1;
        if (cvCnt_q == `PCS_CONV_CYC) begin
          cvState_d = CV_DONE;
        end
      end
      default: begin
        // Held word is sign, chord, step as the converter produced it
        txHold_d = adcSample;
        cvState_d = CV_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cvState_q <= CV_IDLE;
      cvCnt_q <= 4'h0;
      cvPend_q <= 1'b0;
      txHold_q <= 8'h00;
    end else begin
      cvState_q <= cvState_d;
      cvCnt_q <= cvCnt_d;
      cvPend_q <= cvPend_d;
      txHold_q <= txHold_d;
    end
  end

  assign adcStart = (cvState_q == CV_IDLE) & cvPend_q;
  // Null drives magnitude path only; the sign comparator is left alone
  assign adcNull = (cvState_q == CV_NULL);

  // Receive section
  reg [7:0] rxShift_q;
  reg [7:0] rxShift_d;
  reg [3:0] rxCnt_q;
  reg [3:0] rxCnt_d;
  reg rxMaster_q;
  reg rxMaster_d;
  reg [7:0] dac_q;
  reg [7:0] dac_d;
  reg dacStart_q;
  reg dacStart_d;

  wire rxClkEdge;
  wire rxLateEdge;
  wire rxShiftEdge;
  assign rxClkEdge = rxSyncLvl & rxClkRise;
  assign rxLateEdge = rxSyncRise & rxClkLvl;
  assign rxShiftEdge = rxClkEdge | rxLateEdge;

  always @* begin
    rxShift_d = rxShift_q;
    rxCnt_d = rxCnt_q;
    rxMaster_d = rxMaster_q;
    dac_d = dac_q;
    dacStart_d = 1'b0;
    if (rxSyncRise) begin
      rxCnt_d = 4'h0;
    end
    // Master follows data while the internal clock is low
    if (!rxClkLvl) begin
      rxMaster_d = rxDataSync_q;
    end
    // Bits past the eighth are dropped; the count marks a short word
    if (rxShiftEdge && rxCnt_d < `PCS_NINTH_BIT) begin
      // First bit is taken with sync and clock both high
      rxShift_d = {rxShift_q[`PCS_SIGN_POS - 1:0], rxClkRise ? rxMaster_q : rxDataSync_q};
      rxCnt_d = rxCnt_d + 4'h1;
    end
    // A short word still goes to the converter; rxWordValid stays low
    if (rxSyncFall) begin
      dac_d = rxShift_q;
      dacStart_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxShift_q <= 8'h00;
      rxCnt_q <= 4'h0;
      rxMaster_q <= 1'b0;
      dac_q <= 8'h00;
      dacStart_q <= 1'b0;
    end else begin
      rxShift_q <= rxShift_d;
      rxCnt_q <= rxCnt_d;
      rxMaster_q <= rxMaster_d;
      dac_q <= dac_d;
      dacStart_q <= dacStart_d;
    end
  end

  assign dacWord = dac_q;
  assign dacStart = dacStart_q;
  assign rxWordValid = dacStart_q & (rxCnt_q == `PCS_NINTH_BIT);
endmodule // pcs_serial_port

// [pcs_serial_port_monitor.sv]
// Pin-level checker for the PCM serial port.
// Assumes the bind below attaches it to pcs_serial_port.
`timescale 1ns/1ps
module pcs_serial_port_monitor (
  input wire clk,
  input wire rstn,
  input wire txFrameStrobe,
  input wire txData,
  input wire txDataOe,
  input wire rxFrameStrobe,
  input wire adcStart,
  input wire adcNull,
  input wire dacStart,
  input wire rxWordValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Six samples cover the two-flop synchroniser plus edge detect
  a_oe_sync_low: assert property (!txFrameStrobe [*6] |-> !txDataOe)
    else $error("tx driver on while strobe low");
  a_oe_sync_high: assert property (txFrameStrobe [*6] |-> txDataOe)
    else $error("tx driver off while strobe high");
  a_data_idle_zero: assert property (!txDataOe |-> !txData)
    else $error("tx data not parked while disabled");
  a_start_one_cycle: assert property (adcStart |=> !adcStart)
    else $error("conversion start longer than one cycle");
  a_start_in_frame: assert property (adcStart |-> txFrameStrobe)
    else $error("conversion start outside a tx frame");
  a_null_follows: assert property (adcStart |-> ##[0:2] adcNull)
    else $error("no offset null after conversion start");
  a_null_length: assert property ($rose(adcNull) |-> adcNull [*4] ##1 !adcNull)
    else $error("offset null length wrong");
  a_dac_one_cycle: assert property (dacStart |=> !dacStart)
    else $error("dac start longer than one cycle");
  a_dac_after_fall: assert property (dacStart |-> !rxFrameStrobe)
    else $error("dac start while rx strobe high");
  a_valid_with_dac: assert property (rxWordValid |-> dacStart)
    else $error("word valid without dac start");
  c_conv: cover property (adcStart);
  c_word: cover property (dacStart && rxWordValid);
  c_short: cover property (dacStart && !rxWordValid);
endmodule // pcs_serial_port_monitor

bind pcs_serial_port pcs_serial_port_monitor i_pcs_serial_port_monitor (.clk(clk), .rstn(rstn),
  .txFrameStrobe(txFrameStrobe), .txData(txData), .txDataOe(txDataOe),
  .rxFrameStrobe(rxFrameStrobe), .adcStart(adcStart), .adcNull(adcNull),
  .dacStart(dacStart), .rxWordValid(rxWordValid));

// [pcs_highway_model.sv]
// Highway controller model: makes syncs, bit clocks and rx data.
// Assumes calls start on a falling clk edge; bit clocks stand still between frames.
`timescale 1ns/1ps
module pcs_highway_model (
  input wire clk,
  output reg txFrameStrobe = 1'b0,
  output reg txBitClock = 1'b0,
  output reg rxFrameStrobe = 1'b0,
  output reg rxBitClock = 1'b0,
  output reg rxData = 1'b0,
  input wire txData,
  input wire txDataOe
);
  integer i;
  task tx_frame(input late, output [7:0] w, output oe);
    begin
      @(negedge clk);
      oe = 1'b1;
      if (late) begin
        txBitClock = 1'b1;
        #200 txFrameStrobe = 1'b1; // Strobe rises after the clock
      end else begin
        txFrameStrobe = 1'b1;
        #200 txBitClock = 1'b1; // First clock rise after the strobe
      end
      #200 txBitClock = 1'b0; // 800 ns bit period
      for (i = 7; i >= 0; i = i - 1) begin
        #300 w[i] = txData;
        oe = oe & txDataOe;
        if (i > 0) begin
          #100 txBitClock = 1'b1;
          #400 txBitClock = 1'b0;
        end
      end
      #100 txFrameStrobe = 1'b0; // Low again between words
    end
  endtask
  task rx_frame(input [7:0] w, input late, input integer n);
    begin
      @(negedge clk);
      rxData = w[7]; // Sign first
      if (late) begin
        rxBitClock = 1'b1;
        #200 rxFrameStrobe = 1'b1;
      end else begin
        rxFrameStrobe = 1'b1;
        #200 rxBitClock = 1'b1; // Both high in bit one
      end
      for (i = 6; i >= 8 - n; i = i - 1) begin
        #400 rxBitClock = 1'b0;
        #100 rxData = w[i];
        #300 rxBitClock = 1'b1;
      end
      #400 rxBitClock = 1'b0;
      #200 rxFrameStrobe = 1'b0; // Drops before a ninth rise
      #100 rxData = ~rxData; // Stale bit must not linger
    end
  endtask
endmodule // pcs_highway_model

// [tb.sv]
// Self-checking bench for pcs_serial_port with the highway model.
// Assumes a 10 MHz clk; inputs change on falling edges.
`timescale 1ns/1ps
module tb;
  localparam [23:0] CHORDS = 24'hB3E21A;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] adcSample = 8'h00;
  wire txFrameStrobe, txBitClock, txData, txDataOe, rxFrameStrobe, rxBitClock, rxData;
  wire adcStart, adcNull, dacStart, rxWordValid;
  wire [7:0] dacWord;
  integer error_cnt = 0;
  integer tests_run = 0;
  reg [7:0] convCnt = 8'h00;
  reg [7:0] nullCnt = 8'h00;
  // Counted on falling edges, where the converter outputs are settled
  always @(negedge clk) begin
    if (adcStart) convCnt <= convCnt + 8'h01;
    if (adcNull) nullCnt <= nullCnt + 8'h01;
  end
  always #50 clk = ~clk;
  pcs_serial_port i_pcs_serial_port (.clk(clk), .rstn(rstn), .txFrameStrobe(txFrameStrobe),
    .txBitClock(txBitClock), .txData(txData), .txDataOe(txDataOe),
    .rxFrameStrobe(rxFrameStrobe), .rxBitClock(rxBitClock), .rxData(rxData),
    .adcSample(adcSample), .adcStart(adcStart), .adcNull(adcNull), .dacWord(dacWord),
    .dacStart(dacStart), .rxWordValid(rxWordValid));
  pcs_highway_model i_pcs_highway_model (.clk(clk), .txFrameStrobe(txFrameStrobe),
    .txBitClock(txBitClock), .rxFrameStrobe(rxFrameStrobe), .rxBitClock(rxBitClock),
    .rxData(rxData), .txData(txData), .txDataOe(txDataOe));
  task check(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Word sent in frame k is the sample converted during frame k-1
  task test_tx;
    reg [7:0] w, prev;
    reg oe;
    integer k;
    begin
      prev = 8'h00;
      for (k = 0; k < 9; k = k + 1) begin
        adcSample = {k[0], CHORDS[23 - 3 * (k % 8) -: 3], k[3:0] ^ 4'hA};
        i_pcs_highway_model.tx_frame(k[1], w, oe);
        if (k > 0) check("tx word", prev, w);
        check("tx enable", 8'h01, {7'h00, oe});
        repeat (10) @(negedge clk);
        check("tx idle", 8'h00, {6'h00, txDataOe, txData});
        prev = adcSample;
      end
      check("conv starts", 8'h09, convCnt);
      check("null cycles", 8'h24, nullCnt);
      $display("test_tx done");
    end
  endtask
  task rx_case(input [7:0] w, input late, input integer n);
    integer t;
    begin
      i_pcs_highway_model.rx_frame(w, late, n);
      t = 0;
      while (dacStart !== 1'b1 && t < 20) begin
        @(negedge clk);
        t = t + 1;
      end
      check("dac start", 8'h01, {7'h00, dacStart});
      if (n == 8) check("dac word", w, dacWord);
      else check("short word", {1'h0, w[7:1]}, {1'h0, dacWord[6:0]});
      check("word valid", {7'h00, n == 8}, {7'h00, rxWordValid});
      repeat (20) @(negedge clk); // Strobe low over 20 cycles
    end
  endtask
  task test_rx_on_time;
    begin
      rx_case(8'hC5, 1'b0, 8);
      $display("test_rx_on_time done");
    end
  endtask
  task test_rx_late;
    begin
      rx_case(8'h3A, 1'b1, 8);
      $display("test_rx_late done");
    end
  endtask
  task test_rx_short;
    begin
      rx_case(8'h5C, 1'b0, 7);
      $display("test_rx_short done");
    end
  endtask
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    test_tx;
    test_rx_on_time;
    test_rx_late;
    test_rx_short;
    finish_test;
  end
endmodule // tb
